// ==== verilog/icache_diagnostic_access.sv ====
/*
  Diagnostic access port of the instruction cache: location select, two content
  registers, access trigger, and flop arrays standing in for the data, tag and status stores.
  Assumes the core issues at most one register access per cycle and waits for the response.
*/
`timescale 1ns/10ps

module icache_diagnostic_access
  import icache_diag_pkg::*;
#(
  parameter int INDEX_BITS = 14,
  parameter int TAG_BITS   = 20,
  parameter bit USE_ECC    = 1'b0
)(
  input  wire logic     sys_clk,
  input  wire logic     rst,
  input  wire csr_req_t csrReq,
  output csr_rsp_t      csrRsp
);

  localparam int LINE_BITS = INDEX_BITS - CHUNK_SEL_BITS;
  localparam int LINES     = 1 << LINE_BITS;
  localparam int CHUNKS    = 1 << INDEX_BITS;
  localparam int CHK_W     = USE_ECC ? 10 : 2;
  localparam int HALF_CHK  = CHK_W / 2;

  initial
  begin
    if (INDEX_BITS < CHUNK_SEL_BITS + 1 || INDEX_BITS > INDEX_MSB - INDEX_LSB + 1)
      $error("INDEX_BITS out of range");
    if (TAG_BITS < 1 || TAG_BITS > TAG_MSB - TAG_LSB + 1)
      $error("TAG_BITS out of range");
    if (NUM_WAYS != (1 << (WAY_MSB - WAY_LSB + 1)))
      $error("NUM_WAYS does not match the way field");
    if (CHK_W > ECC_UPPER_MSB + 1)
      $error("check bits overflow their register field");
  end

  logic                  arraySel_ff, nxt_arraySel;
  logic [1:0]            way_ff, nxt_way;
  logic [INDEX_BITS-1:0] index_ff, nxt_index;
  logic [31:0]           content_ff, nxt_content;
  logic [CHK_W-1:0]      check_ff, nxt_check;
  csr_rsp_t              rsp_ff, nxt_rsp;

  logic [31:0]           dataArr_ff  [NUM_WAYS][CHUNKS];
  logic [CHK_W-1:0]      dataChk_ff  [NUM_WAYS][CHUNKS];
  logic [TAG_BITS-1:0]   tagArr_ff   [NUM_WAYS][LINES];
  logic [HALF_CHK-1:0]   tagChk_ff   [NUM_WAYS][LINES];
  logic                  validArr_ff [NUM_WAYS][LINES];
  logic [2:0]            lruArr_ff   [LINES];

  logic                  hit;
  logic                  trigRead;
  logic                  trigWrite;
  logic [LINE_BITS-1:0]  lineIdx;
  logic [31:0]           selWord;
  logic [31:0]           contentWord;
  logic [31:0]           checkWord;

  logic                  selHit;
  logic                  contentHit;
  logic                  checkHit;
  logic                  trigHit;
  logic [NUM_WAYS-1:0]   wayWrite;
  logic                  nxt_valid [NUM_WAYS][LINES];
  logic [2:0]            nxt_lru   [LINES];

  // Chunk bits are dropped so every chunk of a line hits the same tag entry.
  assign lineIdx = index_ff[INDEX_BITS-1:CHUNK_SEL_BITS];

  always_comb
  begin
    selWord = RESET_WORD;
    selWord[ARRAY_SEL_BIT] = arraySel_ff;
    selWord[WAY_MSB:WAY_LSB] = way_ff;
    selWord[INDEX_LSB +: INDEX_BITS] = index_ff;
    contentWord = RESET_WORD;
    if (arraySel_ff)
    begin
      contentWord[TAG_LSB +: TAG_BITS] = content_ff[TAG_LSB +: TAG_BITS];
      contentWord[LRU_MSB:LRU_LSB] = content_ff[LRU_MSB:LRU_LSB];
      contentWord[VALID_BIT] = content_ff[VALID_BIT];
    end
    else
    begin
      contentWord = content_ff;
    end
    checkWord = RESET_WORD;
    if (arraySel_ff)
      checkWord[HALF_CHK-1:0] = check_ff[HALF_CHK-1:0];
    else
      checkWord[CHK_W-1:0] = check_ff;
  end

  // Machine-mode accesses are answered as illegal and change no state.
  // Each register gets its own hit; the read mux and the register write paths use only their OR and compare the address again; trigRead and trigWrite use trigHit.
  always_comb
  begin
    selHit     = 1'b0;
    contentHit = 1'b0;
    checkHit   = 1'b0;
    trigHit    = 1'b0;
    if (!csrReq.valid || !csrReq.debugMode)
    begin
      selHit = 1'b0;
    end
    else if (csrReq.addr == ADDR_LOCATION_SELECT)
    begin
      selHit = 1'b1;
    end
    else if (csrReq.addr == ADDR_ARRAY_CONTENT)
    begin
      contentHit = 1'b1;
    end
    else if (csrReq.addr == ADDR_CHECK_BITS)
    begin
      checkHit = 1'b1;
    end
    else if (csrReq.addr == ADDR_ACCESS_TRIGGER)
    begin
      trigHit = 1'b1;
    end
  end

  assign hit       = selHit || contentHit || checkHit || trigHit;
  assign trigRead  = trigHit && !csrReq.write;
  // A trigger write of 0 is accepted but moves nothing.
  assign trigWrite = trigHit && csrReq.write && csrReq.wdata[TRIGGER_BIT];

  // One enable per way keeps each way's store written from a single process.
  always_comb
  begin
    for (int k = 0; k < NUM_WAYS; k++)
      wayWrite[k] = trigWrite && (way_ff == 2'(k));
  end

  always_comb
  begin
    nxt_arraySel = arraySel_ff;
    nxt_way      = way_ff;
    nxt_index    = index_ff;
    nxt_content  = content_ff;
    nxt_check    = check_ff;
    nxt_rsp      = '0;
    nxt_rsp.valid = csrReq.valid;
    nxt_rsp.illegal = csrReq.valid && !hit;
    if (hit && csrReq.write)
    begin
      if (csrReq.addr == ADDR_LOCATION_SELECT)
      begin
        nxt_arraySel = csrReq.wdata[ARRAY_SEL_BIT];
        nxt_way      = csrReq.wdata[WAY_MSB:WAY_LSB];
        nxt_index    = csrReq.wdata[INDEX_LSB +: INDEX_BITS];
      end
      else if (csrReq.addr == ADDR_ARRAY_CONTENT)
      begin
        nxt_content = csrReq.wdata;
      end
      else if (csrReq.addr == ADDR_CHECK_BITS)
      begin
        nxt_check = csrReq.wdata[CHK_W-1:0];
      end
    end
    else if (hit)
    begin
      if (csrReq.addr == ADDR_LOCATION_SELECT)
        nxt_rsp.rdata = selWord;
      else if (csrReq.addr == ADDR_ARRAY_CONTENT)
        nxt_rsp.rdata = contentWord;
      else if (csrReq.addr == ADDR_CHECK_BITS)
        nxt_rsp.rdata = checkWord;
      else
        nxt_rsp.rdata = RESET_WORD;
    end
    // The array read lands in the same edge as the response, so the next access sees it.
    if (trigRead)
    begin
      if (arraySel_ff)
      begin
        nxt_content = RESET_WORD;
        nxt_content[TAG_LSB +: TAG_BITS] = tagArr_ff[way_ff][lineIdx];
        nxt_content[LRU_MSB:LRU_LSB] = lruArr_ff[lineIdx];
        nxt_content[VALID_BIT] = validArr_ff[way_ff][lineIdx];
        nxt_check = '0;
        nxt_check[HALF_CHK-1:0] = tagChk_ff[way_ff][lineIdx];
      end
      else
      begin
        nxt_content = dataArr_ff[way_ff][index_ff];
        nxt_check   = dataChk_ff[way_ff][index_ff];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      arraySel_ff <= 1'b0;
      way_ff      <= '0;
      index_ff    <= '0;
      content_ff  <= RESET_WORD;
      check_ff    <= '0;
      rsp_ff      <= '0;
    end
    else
    begin
      arraySel_ff <= nxt_arraySel;
      way_ff      <= nxt_way;
      index_ff    <= nxt_index;
      content_ff  <= nxt_content;
      check_ff    <= nxt_check;
      rsp_ff      <= nxt_rsp;
    end
  end

  assign csrRsp = rsp_ff;

  // Arrays are not reset, like the SRAMs they model; only valid and LRU flops clear.
  // Software must write a location before reading it back, or it sees unknown contents.
  genvar w;
  generate
    for (w = 0; w < NUM_WAYS; w++)
    begin : gWay
      always_ff @(posedge sys_clk)
      begin
        if (wayWrite[w])
        begin
          if (arraySel_ff)
          begin
            tagArr_ff[w][lineIdx] <= content_ff[TAG_LSB +: TAG_BITS];
            tagChk_ff[w][lineIdx] <= check_ff[HALF_CHK-1:0];
          end
          else
          begin
            dataArr_ff[w][index_ff] <= content_ff;
            dataChk_ff[w][index_ff] <= check_ff;
          end
        end
      end
    end
  endgenerate

  // Status bits live in flops so they can be cleared at reset, unlike the arrays.
  // The LRU bits belong to the set, so a tag write to any way replaces them.
  always_comb
  begin
    nxt_valid = validArr_ff;
    nxt_lru   = lruArr_ff;
    if (trigWrite && arraySel_ff)
    begin
      nxt_lru[lineIdx]           = content_ff[LRU_MSB:LRU_LSB];
      nxt_valid[way_ff][lineIdx] = content_ff[VALID_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int l = 0; l < LINES; l++)
      begin
        lruArr_ff[l] <= 3'h0;
        for (int v = 0; v < NUM_WAYS; v++)
          validArr_ff[v][l] <= 1'b0;
      end
    end
    else
    begin
      validArr_ff <= nxt_valid;
      lruArr_ff   <= nxt_lru;
    end
  end

endmodule

// ==== shared/icache_diag_pkg.sv ====
/*
  Constants, field layouts and carrier types for the instruction cache diagnostic port.
  Assumes a core that presents register accesses as one-cycle strobes with a 12-bit address.
*/
package icache_diag_pkg;

  localparam logic [11:0] ADDR_LOCATION_SELECT = 12'h07c8;
  localparam logic [11:0] ADDR_ARRAY_CONTENT   = 12'h07c9;
  localparam logic [11:0] ADDR_CHECK_BITS      = 12'h07ca;
  localparam logic [11:0] ADDR_ACCESS_TRIGGER  = 12'h07cb;

  localparam int ARRAY_SEL_BIT  = 24;
  localparam int WAY_LSB        = 20;
  localparam int WAY_MSB        = 21;
  localparam int INDEX_LSB      = 2;
  localparam int INDEX_MSB      = 15;
  localparam int TRIGGER_BIT    = 0;
  localparam int TAG_LSB        = 12;
  localparam int TAG_MSB        = 31;
  localparam int LRU_LSB        = 4;
  localparam int LRU_MSB        = 6;
  localparam int VALID_BIT      = 0;
  localparam int PAR_UPPER_BIT  = 1;
  localparam int PAR_LOWER_BIT  = 0;
  localparam int ECC_UPPER_LSB  = 5;
  localparam int ECC_UPPER_MSB  = 9;
  localparam int ECC_LOWER_LSB  = 0;
  localparam int ECC_LOWER_MSB  = 4;
  localparam int NUM_WAYS       = 4;
  localparam int CHUNKS_PER_LINE = 16;
  localparam int CHUNK_SEL_BITS = 4;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] MASK_PARITY_CHECK = 32'h0000_0003;
  localparam logic [31:0] MASK_ECC_CHECK    = 32'h0000_03ff;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        debugMode;
  } csr_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
    logic        illegal;
  } csr_rsp_t;

endpackage

// ==== dv/icache_diag_chk.sv ====
/*
  Port checker for the cache diagnostic block.
  Assumes synchronous active-high reset and one response per request.
*/
`timescale 1ns/10ps
module icache_diag_chk
  import icache_diag_pkg::*;
#(
  parameter int INDEX_BITS = 14
)(
  input wire logic     sys_clk,
  input wire logic     rst,
  input wire csr_req_t csrReq,
  input wire csr_rsp_t csrRsp
);
  localparam logic [31:0] SEL_MASK = 32'h0130_0000 | (((32'h1 << INDEX_BITS) - 1) << 2);
  wire logic rdOk = csrReq.valid && csrReq.debugMode && !csrReq.write;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_rsp_next_cycle:
    assert property (csrReq.valid |=> csrRsp.valid) else $error("late response");
  a_rsp_has_cause:
    assert property (csrRsp.valid |-> $past(csrReq.valid)) else $error("stray response");
  a_machine_refused:
    assert property (csrReq.valid && !csrReq.debugMode |=> csrRsp.illegal && csrRsp.rdata == 0)
    else $error("access not refused");
  a_debug_accepted:
    assert property (csrReq.valid && csrReq.debugMode && csrReq.addr[11:2] == 10'h1f2
      |=> !csrRsp.illegal) else $error("access refused");
  a_go_reads_zero:
    assert property (rdOk && csrReq.addr == ADDR_ACCESS_TRIGGER |=> csrRsp.rdata == 0)
    else $error("trigger read nonzero");
  a_sel_reserved:
    assert property (rdOk && csrReq.addr == ADDR_LOCATION_SELECT
      |=> (csrRsp.rdata & ~SEL_MASK) == 0) else $error("select reserved set");
  a_chk_reserved:
    assert property (rdOk && csrReq.addr == ADDR_CHECK_BITS |=> csrRsp.rdata[31:10] == 0)
    else $error("check reserved set");
  a_sel_readback:
    assert property (csrReq.valid && csrReq.debugMode && csrReq.write
      && csrReq.addr == ADDR_LOCATION_SELECT ##1 rdOk && csrReq.addr == ADDR_LOCATION_SELECT
      |=> csrRsp.rdata == ($past(csrReq.wdata, 2) & SEL_MASK)) else $error("select readback");
endmodule
bind icache_diagnostic_access icache_diag_chk #(.INDEX_BITS(INDEX_BITS)) u_chk (
  .sys_clk(sys_clk),
  .rst    (rst),
  .csrReq (csrReq),
  .csrRsp (csrRsp)
);

// ==== dv/icache_diagnostic_access_tb.sv ====
/*
  Testbench: register access sequences with expected values.
  Assumes the checker is bound in and a six-bit index.
*/
`timescale 1ns/10ps
module icache_diagnostic_access_tb;
  import icache_diag_pkg::*;
  logic     sys_clk    = 1'b0;
  logic     rst        = 1'b1;
  csr_req_t req        = '0;
  csr_rsp_t rsp;
  csr_rsp_t s;
  csr_rsp_t s2;
  int       mismatches = 0;
  int       num_checks = 0;
  always #4 sys_clk = ~sys_clk;
  icache_diagnostic_access #(.INDEX_BITS(6)) dut (
    .sys_clk(sys_clk),
    .rst    (rst),
    .csrReq (req),
    .csrRsp (rsp)
  );
  function automatic csr_req_t rq(logic w, logic [11:0] a, logic [31:0] d, logic g = 1'b1);
    return '{1'b1, w, a, d, g};
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Second request follows the first with no gap; the idle cycle after keeps calls apart.
  task automatic acc2(csr_req_t a, csr_req_t b);
    @(posedge sys_clk);
    req <= a;
    @(posedge sys_clk);
    req <= b;
    @(negedge sys_clk);
    s = rsp;
    @(posedge sys_clk);
    req <= '0;
    @(negedge sys_clk);
    s2 = rsp;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    acc2(rq(1'b1, a, d), '0);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp);
    acc2(rq(1'b0, a, '0), '0);
    chk(s.rdata, exp);
  endtask
  task automatic store(logic [31:0] sel, logic [31:0] d0, logic [31:0] d1);
    wr(ADDR_LOCATION_SELECT, sel);
    wr(ADDR_ARRAY_CONTENT, d0);
    wr(ADDR_CHECK_BITS, d1);
    wr(ADDR_ACCESS_TRIGGER, 32'h0000_0001);
  endtask
  task automatic fetch(logic [31:0] sel, logic [31:0] e0, logic [31:0] e1);
    wr(ADDR_LOCATION_SELECT, sel);
    acc2(rq(1'b0, ADDR_ACCESS_TRIGGER, '0), rq(1'b0, ADDR_ARRAY_CONTENT, '0));
    chk(s.rdata, '0);
    chk(s2.rdata, e0);
    rd(ADDR_CHECK_BITS, e1);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      rd(ADDR_LOCATION_SELECT + 12'(i), '0);
    $display("reset values done");
    wr(ADDR_LOCATION_SELECT, 32'hFFFF_FFFF);
    rd(ADDR_LOCATION_SELECT, 32'h0130_00FC);
    acc2(rq(1'b1, ADDR_LOCATION_SELECT, 32'h0000_0010), rq(1'b0, ADDR_LOCATION_SELECT, '0));
    chk(s2.rdata, 32'h0000_0010);
    wr(ADDR_CHECK_BITS, 32'hFFFF_FFFF);
    rd(ADDR_CHECK_BITS, 32'h0000_0003);
    $display("register fields done");
    for (int i = 0; i < 4; i++)
      store({10'h0, 2'(i), 14'h0, 4'(i * 5), 2'h0}, 32'hA5C3_E1F0 + 32'(i), 32'(i));
    wr(ADDR_ARRAY_CONTENT, 32'hFFFF_FFFF);
    wr(ADDR_ACCESS_TRIGGER, 32'h0000_0002);
    for (int i = 0; i < 4; i++)
      fetch({10'h0, 2'(i), 14'h0, 4'(i * 5), 2'h0}, 32'hA5C3_E1F0 + 32'(i), 32'(i));
    $display("data array done");
    store(32'h0100_0040, 32'hABCD_EFFF, 32'h0000_0003);
    store(32'h0110_004C, 32'h1111_1020, 32'h0000_0000);
    fetch(32'h0100_0044, 32'hABCD_E021, 32'h0000_0001);
    fetch(32'h0110_0040, 32'h1111_1020, 32'h0000_0000);
    $display("tag array done");
    acc2(rq(1'b1, ADDR_LOCATION_SELECT, 32'h0000_0020, 1'b0), rq(1'b0, 12'h07cc, '0));
    chk(32'({s.illegal, s2.illegal}), 32'h0000_0003);
    rd(ADDR_LOCATION_SELECT, 32'h0110_0040);
    $display("refusal done");
    summarize();
  end
endmodule
